// File: design/ldp_ctrl.sv
`timescale 1ns/1ps
`include "ldp_params.svh"

module ldp_ctrl #(
  parameter logic [4:0] CAL_LINE = 5'h10
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        SCL,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE,
  input  wire logic        SANDCASTLE_INPUT_IN,
  input  wire logic        VBLANK_IN,
  output logic [4:0]       DELAY_TAP,
  output logic [10:0]      LUMA_DELAY_NS,
  output logic             SC_LEVEL_5V,
  output logic             CORING_EN,
  output logic             PEAK_DELAY_EN,
  output logic             PEAK_FREQ_LOW,
  output logic [3:0]       PEAK_GAIN_CODE,
  output logic signed [4:0] PEAK_GAIN_DB,
  output logic             CLAMP_PULSE,
  output logic             CAL_EN,
  output logic [4:0]       BK_COUNT,
  output logic             BK_COUNT_OK
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic             scl_s1_q, scl_s2_q, scl_s3_q, scl_f_q;
  logic             sda_s1_q, sda_s2_q, sda_s3_q, sda_f_q, sda_fd_q;
  logic             start_evt, stop_evt;
  logic             link_rst_n_q;
  logic [1:0]       hold_cnt_q;
  logic [3:0]       bit_cnt_q;
  logic [7:0]       shift_q;
  logic [7:0]       byte_in;
  ldp_pkg::ldp_state_t state_q;
  logic             ack_q;
  logic             pend_q;
  logic             sda_oe_q;
  logic [7:0]       ptr_q;
  logic [7:0]       tx_q;
  logic [7:0]       wr_addr_q;
  logic [7:0]       wr_data_q;
  logic             wr_tgl_q;
  logic [7:0]       rd0_s1_q, rd0_s2_q, rd1_s1_q, rd1_s2_q;
  logic             tg_s1_q, tg_s2_q, tg_s3_q, tg_f_q, tg_fd_q;
  logic             wr_evt;
  logic [7:0]       reg_delay_q;
  logic [7:0]       reg_peak_q;
  logic             bk_s1_q, bk_s2_q, bk_s3_q, bk_f_q, bk_fd_q;
  logic             vb_s1_q, vb_s2_q, vb_s3_q, vb_f_q, vb_fd_q;
  logic             bk_rise;
  logic [7:0]       clamp_cnt_q;
  logic [4:0]       bk_cnt_q;
  logic             bk_wrap_q;
  logic             sda_o_q;

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic sub_ok(input logic [7:0] sub);
    sub_ok = (sub == `LDP_SUB_DELAY) || (sub == `LDP_SUB_PEAK);
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] sub);
    if (sub == `LDP_SUB_DELAY)
      rd_byte = rd0_s2_q;
    else if (sub == `LDP_SUB_PEAK)
      rd_byte = rd1_s2_q;
    else
      rd_byte = `LDP_UNMAPPED_BYTE;
  endfunction

  function automatic logic [10:0] tap_delay(input logic [4:0] tap);
    tap_delay = (tap[0] ? `LDP_TAP0_NS : 11'h000)
              + (tap[1] ? `LDP_TAP1_NS : 11'h000)
              + (tap[2] ? `LDP_TAP2_NS : 11'h000)
              + (tap[3] ? `LDP_TAP3_NS : 11'h000)
              + (tap[4] ? `LDP_TAP4_NS : 11'h000);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // bus pin synchronisers and filters on MCLK
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      scl_f_q  <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      sda_f_q  <= 1'b1;
      sda_fd_q <= 1'b1;
    end else begin
      scl_s1_q <= SCL;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= SDA_I;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      if (scl_s2_q == scl_s3_q) scl_f_q <= scl_s2_q;
      if (sda_s2_q == sda_s3_q) sda_f_q <= sda_s2_q;
      sda_fd_q <= sda_f_q;
    end
  end

  // start and stop seen while the clock is high
  assign start_evt = scl_f_q & sda_fd_q & ~sda_f_q;
  assign stop_evt  = scl_f_q & ~sda_fd_q & sda_f_q;

  // frame reset: pulse on start, held from stop to next start
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      link_rst_n_q <= 1'b0;
      hold_cnt_q   <= 2'h0;
    end else if (stop_evt) begin
      link_rst_n_q <= 1'b0;
      hold_cnt_q   <= 2'h0;
    end else if (start_evt) begin
      link_rst_n_q <= 1'b0;
      hold_cnt_q   <= 2'(`LDP_START_HOLD_CYC);
    end else if (hold_cnt_q != 2'h0) begin
      hold_cnt_q <= hold_cnt_q - 2'h1;
      if (hold_cnt_q == 2'h1) link_rst_n_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain: byte engine on rising SCL, cleared per frame
  assign byte_in = {shift_q[6:0], SDA_I};

  always_ff @(posedge SCL or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      state_q   <= ldp_pkg::ST_ADDR;
      ack_q     <= 1'b0;
      pend_q    <= 1'b0;
    end else begin
      if (bit_cnt_q == 4'h8) bit_cnt_q <= 4'h0;
      else bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q != 4'h8) shift_q <= byte_in;
      if (bit_cnt_q == 4'h0) pend_q <= 1'b0;
      if (bit_cnt_q == 4'h7) begin
        ack_q <= 1'b0;
        unique case (state_q)
          ldp_pkg::ST_ADDR: begin
            if (byte_in[7:1] == `LDP_SLAVE_ADDR) begin
              ack_q   <= 1'b1;
              state_q <= byte_in[0] ? ldp_pkg::ST_RDATA : ldp_pkg::ST_SUB;
            end else begin
              state_q <= ldp_pkg::ST_IGNORE;
            end
          end
          ldp_pkg::ST_SUB: begin
            if (sub_ok(byte_in)) begin
              ack_q   <= 1'b1;
              state_q <= ldp_pkg::ST_WDATA;
            end else begin
              state_q <= ldp_pkg::ST_IGNORE;
            end
          end
          ldp_pkg::ST_WDATA: begin
            if (sub_ok(ptr_q)) begin
              ack_q  <= 1'b1;
              pend_q <= 1'b1;
            end else begin
              state_q <= ldp_pkg::ST_IGNORE;
            end
          end
          ldp_pkg::ST_RDATA, ldp_pkg::ST_IGNORE: begin
          end
          default: state_q <= ldp_pkg::ST_IGNORE;
        endcase
      end
      // master refusal ends a read
      if (bit_cnt_q == 4'h8 && state_q == ldp_pkg::ST_RDATA && SDA_I)
        state_q <= ldp_pkg::ST_IGNORE;
    end
  end

  // pointer and held write, kept across frames
  always_ff @(posedge SCL or negedge RST_N) begin
    if (!RST_N) begin
      ptr_q     <= 8'h00;
      tx_q      <= 8'h00;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else if (bit_cnt_q == 4'h7) begin
      if (state_q == ldp_pkg::ST_SUB) begin
        ptr_q <= byte_in;
      end else if (state_q == ldp_pkg::ST_WDATA && sub_ok(ptr_q)) begin
        wr_addr_q <= ptr_q;
        wr_data_q <= byte_in;
        ptr_q     <= ptr_q + 8'h01;
      end else if (state_q == ldp_pkg::ST_ADDR && byte_in[0]) begin
        tx_q <= rd_byte(ptr_q);
      end
    end else if (bit_cnt_q == 4'h8 && state_q == ldp_pkg::ST_RDATA && !SDA_I && !sda_oe_q) begin
      ptr_q <= ptr_q + 8'h01;
      tx_q  <= rd_byte(ptr_q + 8'h01);
    end
  end

  // data line drive on falling SCL
  always_ff @(negedge SCL or negedge link_rst_n_q) begin
    if (!link_rst_n_q)
      sda_oe_q <= 1'b0;
    else if (bit_cnt_q == 4'h8)
      sda_oe_q <= ack_q;
    else if (state_q == ldp_pkg::ST_RDATA)
      sda_oe_q <= ~tx_q[3'h7 - bit_cnt_q[2:0]];
    else
      sda_oe_q <= 1'b0;
  end

  // write event once the acknowledge clock has fallen
  always_ff @(negedge SCL or negedge RST_N) begin
    if (!RST_N)
      wr_tgl_q <= 1'b0;
    else if (bit_cnt_q == 4'h0 && pend_q)
      wr_tgl_q <= ~wr_tgl_q;
  end

  // register copies for reads, quasi-static
  always_ff @(posedge SCL or negedge RST_N) begin
    if (!RST_N) begin
      rd0_s1_q <= `LDP_REG_RESET;
      rd0_s2_q <= `LDP_REG_RESET;
      rd1_s1_q <= `LDP_REG_RESET;
      rd1_s2_q <= `LDP_REG_RESET;
    end else begin
      rd0_s1_q <= reg_delay_q;
      rd0_s2_q <= rd0_s1_q;
      rd1_s1_q <= reg_peak_q;
      rd1_s2_q <= rd1_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write toggle crossing into MCLK
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
      tg_f_q  <= 1'b0;
      tg_fd_q <= 1'b0;
    end else begin
      tg_s1_q <= wr_tgl_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
      if (tg_s2_q == tg_s3_q) tg_f_q <= tg_s2_q;
      tg_fd_q <= tg_f_q;
    end
  end

  assign wr_evt = tg_f_q ^ tg_fd_q;

  // control registers, zero bits forced on write
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      reg_delay_q <= `LDP_REG_RESET;
      reg_peak_q  <= `LDP_REG_RESET;
    end else if (wr_evt) begin
      if (wr_addr_q == `LDP_SUB_DELAY)
        reg_delay_q <= wr_data_q & `LDP_MASK_DELAY;
      else if (wr_addr_q == `LDP_SUB_PEAK)
        reg_peak_q <= wr_data_q & `LDP_MASK_PEAK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decoded control outputs
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      DELAY_TAP      <= 5'h01;
      LUMA_DELAY_NS  <= `LDP_TAP0_NS;
      SC_LEVEL_5V    <= 1'b0;
      CORING_EN      <= 1'b0;
      PEAK_DELAY_EN  <= 1'b0;
      PEAK_FREQ_LOW  <= 1'b0;
      PEAK_GAIN_CODE <= 4'h1;
      PEAK_GAIN_DB   <= 5'h08;
      sda_o_q        <= 1'b0;
    end else begin
      DELAY_TAP      <= reg_delay_q[`LDP_TAP_MSB:0];
      LUMA_DELAY_NS  <= tap_delay(reg_delay_q[`LDP_TAP_MSB:0]);
      SC_LEVEL_5V    <= reg_delay_q[`LDP_SC_BIT];
      CORING_EN      <= reg_peak_q[`LDP_COR_BIT];
      PEAK_DELAY_EN  <= reg_peak_q[`LDP_PDLY_BIT];
      PEAK_FREQ_LOW  <= reg_peak_q[`LDP_LCF_BIT];
      PEAK_GAIN_CODE <= reg_peak_q[`LDP_GAIN_MSB:0];
      PEAK_GAIN_DB   <= `LDP_GAIN_TOP_DB - {1'b0, reg_peak_q[`LDP_GAIN_MSB:0]};
      sda_o_q        <= 1'b0;
    end
  end

  assign SDA_O  = sda_o_q;
  assign SDA_OE = sda_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // sandcastle burst key and blanking synchronisers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      bk_s1_q <= 1'b0;
      bk_s2_q <= 1'b0;
      bk_s3_q <= 1'b0;
      bk_f_q  <= 1'b0;
      bk_fd_q <= 1'b0;
      vb_s1_q <= 1'b0;
      vb_s2_q <= 1'b0;
      vb_s3_q <= 1'b0;
      vb_f_q  <= 1'b0;
      vb_fd_q <= 1'b0;
    end else begin
      bk_s1_q <= SANDCASTLE_INPUT_IN;
      bk_s2_q <= bk_s1_q;
      bk_s3_q <= bk_s2_q;
      if (bk_s2_q == bk_s3_q) bk_f_q <= bk_s2_q;
      bk_fd_q <= bk_f_q;
      vb_s1_q <= VBLANK_IN;
      vb_s2_q <= vb_s1_q;
      vb_s3_q <= vb_s2_q;
      if (vb_s2_q == vb_s3_q) vb_f_q <= vb_s2_q;
      vb_fd_q <= vb_f_q;
    end
  end

  assign bk_rise = bk_f_q & ~bk_fd_q;

  // clamp pulse: delayed lead, ends with the burst key
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      clamp_cnt_q <= 8'h00;
      CLAMP_PULSE <= 1'b0;
    end else if (!bk_f_q) begin
      clamp_cnt_q <= 8'h00;
      CLAMP_PULSE <= 1'b0;
    end else if (bk_rise) begin
      clamp_cnt_q <= 8'(`LDP_CLAMP_DELAY_CYC);
    end else if (clamp_cnt_q != 8'h00) begin
      clamp_cnt_q <= clamp_cnt_q - 8'h01;
      if (clamp_cnt_q == 8'h01) CLAMP_PULSE <= 1'b1;
    end
  end

  // burst keys counted per blanking interval, wrapping past 31
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      bk_cnt_q  <= 5'h00;
      bk_wrap_q <= 1'b0;
    end else if (vb_f_q && !vb_fd_q) begin
      bk_cnt_q  <= 5'h00;
      bk_wrap_q <= 1'b0;
    end else if (vb_f_q && bk_rise) begin
      bk_cnt_q <= bk_cnt_q + 5'h01;
      if (bk_cnt_q == 5'h1F) bk_wrap_q <= 1'b1;
    end
  end

  // calibration window and count report
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CAL_EN      <= 1'b0;
      BK_COUNT    <= 5'h00;
      BK_COUNT_OK <= 1'b0;
    end else begin
      CAL_EN   <= vb_f_q && (bk_cnt_q == CAL_LINE);
      BK_COUNT <= bk_cnt_q;
      if (!vb_f_q && vb_fd_q)
        BK_COUNT_OK <= !bk_wrap_q && (bk_cnt_q >= `LDP_BK_MIN);
    end
  end

endmodule // ldp_ctrl

// File: design/ldp_params.svh
`ifndef LDP_PARAMS_SVH
`define LDP_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// bus addressing
`define LDP_SLAVE_ADDR      7'h44
`define LDP_SUB_DELAY       8'h10
`define LDP_SUB_PEAK        8'h11
`define LDP_UNMAPPED_BYTE   8'hFF

////////////////////////////////////////////////////////////////////////////////
// register layout and reset values
`define LDP_REG_RESET       8'h01
`define LDP_MASK_DELAY      8'h5F
`define LDP_MASK_PEAK       8'hEF
`define LDP_SC_BIT          6
`define LDP_TAP_MSB         4
`define LDP_COR_BIT         7
`define LDP_PDLY_BIT        6
`define LDP_LCF_BIT         5
`define LDP_GAIN_MSB        3

////////////////////////////////////////////////////////////////////////////////
// delay tap weights and gain mapping
`define LDP_TAP0_NS         11'h02D
`define LDP_TAP1_NS         11'h05A
`define LDP_TAP2_NS         11'h0B4
`define LDP_TAP3_NS         11'h0B4
`define LDP_TAP4_NS         11'h1C2
`define LDP_GAIN_TOP_DB     5'h09

////////////////////////////////////////////////////////////////////////////////
// timing
`define LDP_MCLK_MHZ        200
`define LDP_CLAMP_DELAY_NS  1000
`define LDP_CLAMP_DELAY_CYC ((`LDP_CLAMP_DELAY_NS * `LDP_MCLK_MHZ) / 1000)
`define LDP_START_HOLD_CYC  2
`define LDP_BK_MIN          5'h04

`endif

// File: design/ldp_pkg.sv
package ldp_pkg;

  // slave byte-level states, gray along addr -> sub -> wdata
  typedef enum logic [2:0] {
    ST_ADDR   = 3'b000,
    ST_SUB    = 3'b001,
    ST_WDATA  = 3'b011,
    ST_RDATA  = 3'b010,
    ST_IGNORE = 3'b110
  } ldp_state_t;

endpackage

// File: dv/ldp_ctrl_sva.sv
`timescale 1ns/1ps
module ldp_ctrl_chk #(
  parameter logic [4:0] CAL_LINE = 5'h10
) (
  input wire logic              MCLK,
  input wire logic              RST_N,
  input wire logic              SDA_O,
  input wire logic              SDA_OE,
  input wire logic              SANDCASTLE_INPUT_IN,
  input wire logic              VBLANK_IN,
  input wire logic [4:0]        DELAY_TAP,
  input wire logic [10:0]       LUMA_DELAY_NS,
  input wire logic              CORING_EN,
  input wire logic [3:0]        PEAK_GAIN_CODE,
  input wire logic signed [4:0] PEAK_GAIN_DB,
  input wire logic              CLAMP_PULSE,
  input wire logic              CAL_EN,
  input wire logic [4:0]        BK_COUNT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // register-derived outputs
  property p_luma_sum;
    $stable(DELAY_TAP)[*3] |-> LUMA_DELAY_NS == (DELAY_TAP[0] ? 11'h02D : 11'h000)
      + (DELAY_TAP[1] ? 11'h05A : 11'h000) + (DELAY_TAP[2] ? 11'h0B4 : 11'h000)
      + (DELAY_TAP[3] ? 11'h0B4 : 11'h000) + (DELAY_TAP[4] ? 11'h1C2 : 11'h000);
  endproperty
  a_luma_sum: assert property (p_luma_sum) else $error("luma delay not tap sum");
  property p_gain_db;
    $stable(PEAK_GAIN_CODE)[*3] |-> PEAK_GAIN_DB == 5'(5'h09 - {1'b0, PEAK_GAIN_CODE});
  endproperty
  a_gain_db: assert property (p_gain_db) else $error("gain grade wrong");
  property p_rst_val;
    $rose(RST_N) |-> DELAY_TAP == 5'h01 && PEAK_GAIN_CODE == 4'h1 && !CORING_EN;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset value wrong");
  property p_sda_low;
    SDA_O == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
  ////////////////////////////////////////////////////////////////////////////////
  // burst key timing
  property p_bk_step;
    $changed(BK_COUNT) |-> BK_COUNT == 5'($past(BK_COUNT) + 5'h01) || BK_COUNT == 5'h00;
  endproperty
  a_bk_step: assert property (p_bk_step) else $error("key count jumped");
  property p_cal_line;
    CAL_EN |-> BK_COUNT == CAL_LINE || $past(BK_COUNT) == CAL_LINE;
  endproperty
  a_cal_line: assert property (p_cal_line) else $error("calibration off line");
  property p_cal_vbl;
    (!VBLANK_IN)[*8] |-> !CAL_EN;
  endproperty
  a_cal_vbl: assert property (p_cal_vbl) else $error("calibration outside blank");
  property p_clamp_dly;
    $rose(SANDCASTLE_INPUT_IN) |-> ##[200:212] CLAMP_PULSE;
  endproperty
  a_clamp_dly: assert property (p_clamp_dly) else $error("clamp pulse late");
  property p_clamp_early;
    $rose(CLAMP_PULSE) |-> $past(SANDCASTLE_INPUT_IN, 190);
  endproperty
  a_clamp_early: assert property (p_clamp_early) else $error("clamp pulse early");
  c_cal: cover property ($rose(CAL_EN));
  c_clamp: cover property ($rose(CLAMP_PULSE));
  c_ack: cover property ($rose(SDA_OE));
endmodule // ldp_ctrl_chk

bind ldp_ctrl ldp_ctrl_chk #(.CAL_LINE(CAL_LINE)) i_chk (
  .MCLK(MCLK), .RST_N(RST_N), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SANDCASTLE_INPUT_IN(SANDCASTLE_INPUT_IN),
  .VBLANK_IN(VBLANK_IN), .DELAY_TAP(DELAY_TAP), .LUMA_DELAY_NS(LUMA_DELAY_NS),
  .CORING_EN(CORING_EN), .PEAK_GAIN_CODE(PEAK_GAIN_CODE), .PEAK_GAIN_DB(PEAK_GAIN_DB),
  .CLAMP_PULSE(CLAMP_PULSE), .CAL_EN(CAL_EN), .BK_COUNT(BK_COUNT));

// File: dv/ldp_i2c_master.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// bus master model, clock idles high between frames, data line pulled up
module ldp_i2c_master (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  // idle bus at time zero
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // start or repeated start, long hold after data falls
  task automatic start;
    #1 sda_m = 1'b1;
    #62.5 scl = 1'b1;
    #62.5 sda_m = 1'b0;
    #125 scl = 1'b0;
  endtask

  // stop: data rises while clock high, then bus left released
  task automatic stop;
    #5 sda_m = 1'b0;
    #57.5 scl = 1'b1;
    #62.5 sda_m = 1'b1;
    #125;
  endtask

  // one clock: data set in low phase, wire sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    #5 sda_m = b;
    #57.5 scl = 1'b1;
    #31 r = sda;
    #31.5 scl = 1'b0;
  endtask

  // one byte msb first, then the ninth clock
  task automatic xfer(input logic [7:0] d, input logic ak_in, output logic [7:0] q,
                      output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak_in, ak);
  endtask
endmodule // ldp_i2c_master

// File: dv/tb_luma_delay_peaking_ctrl.sv
`timescale 1ns/1ps
module tb_luma_delay_peaking_ctrl;
  logic             mclk;
  logic             rst_n;
  logic             sandcastle_input;
  logic             vblank;
  wire              scl, sda_m, sda_o, sda_oe;
  wire              sda = (sda_oe ? sda_o : 1'b1) & sda_m;
  wire  [4:0]       tap, bk;
  wire  [10:0]      luma;
  wire              sc, cor, pdly, peak_freq_low_select, clamp, cal, bk_ok;
  wire  [3:0]       gcode;
  wire signed [4:0] gdb;
  int               err_count, n_tests;
  logic [7:0]       q0, q1, d0, d1;
  logic [3:0]       ak;
  logic             a;
  logic [10:0]      el;
  logic [4:0]       ed;
  logic [7:0]       bad [3] = '{8'h8A, 8'h00, 8'h98};
  logic [31:0]      rows [4] = '{{8'h1F, 8'h00, 11'h3B1, 5'h09}, {8'h40, 8'hFF, 11'h000, 5'h1A},
                                 {8'h15, 8'hA9, 11'h2A3, 5'h00}, {8'hFF, 8'h48, 11'h3B1, 5'h01}};

  ldp_i2c_master i_mst (.scl(scl), .sda_m(sda_m), .sda(sda));
  ldp_ctrl i_dut (.MCLK(mclk), .RST_N(rst_n), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .SANDCASTLE_INPUT_IN(sandcastle_input), .VBLANK_IN(vblank), .DELAY_TAP(tap), .LUMA_DELAY_NS(luma),
    .SC_LEVEL_5V(sc), .CORING_EN(cor), .PEAK_DELAY_EN(pdly), .PEAK_FREQ_LOW(peak_freq_low_select),
    .PEAK_GAIN_CODE(gcode), .PEAK_GAIN_DB(gdb), .CLAMP_PULSE(clamp), .CAL_EN(cal),
    .BK_COUNT(bk), .BK_COUNT_OK(bk_ok));
  ////////////////////////////////////////////////////////////////////////////////
  // compare, verdict, bus and burst key helpers
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wf(input logic [31:0] b, input int n);
    ak = 4'hF;
    i_mst.start;
    for (int i = 0; i < n; i++) i_mst.xfer(b[31-8*i -: 8], 1'b1, q0, ak[3-i]);
    i_mst.stop;
    repeat (20) @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] sub);
    wf({8'h88, sub, 16'h0000}, 2);
    i_mst.start;
    i_mst.xfer(8'h89, 1'b1, q0, a);
    i_mst.xfer(8'hFF, 1'b0, q0, a);
    i_mst.xfer(8'hFF, 1'b1, q1, a);
    i_mst.stop;
  endtask
  task automatic key;
    sandcastle_input <= 1'b1;
    repeat (230) @(posedge mclk);
    chk("clamp", clamp, 1'b1);
    repeat (20) @(posedge mclk);
    sandcastle_input <= 1'b0;
    repeat (50) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    complete_run;
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    sandcastle_input = 1'b0;
    vblank = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("tap", tap, 5'h01);
    chk("db", gdb[4:0], 5'h08);
    rd(8'h10);
    chk("rd", {q0, q1}, 16'h0101);
    foreach (rows[k]) begin
      {d0, d1, el, ed} = rows[k];
      wf({8'h88, 8'h10, d0, d1}, 4);
      chk("ack", ak, 4'h0);
      chk("tap", tap, d0[4:0]);
      chk("sc", sc, d0[6]);
      chk("luma", luma, el);
      chk("peak", {cor, pdly, peak_freq_low_select, gcode}, {d1[7:5], d1[3:0]});
      chk("db", gdb[4:0], ed);
      rd(8'h10);
      chk("rd", {q0, q1}, {d0 & 8'h5F, d1 & 8'hEF});
    end
    for (int c = 0; c < 16; c++) begin
      wf({8'h88, 8'h11, 4'h0, c[3:0], 8'h00}, 4);
      chk("ack", ak, 4'h1);
      chk("db", gdb[4:0], 5'(5'h09 - c[4:0]));
    end
    foreach (bad[j]) begin
      wf({bad[j], 8'h10, 16'h0000}, 3);
      chk("nack", ak, 4'hF);
    end
    wf({8'h88, 8'h0F, 16'h0000}, 4);
    chk("nack", ak, 4'h7);
    i_mst.start;
    i_mst.xfer(8'h88, 1'b1, q0, a);
    i_mst.xfer(8'h10, 1'b1, q0, a);
    repeat (4) i_mst.bit_io(1'b0, a);
    i_mst.stop;
    repeat (20) @(posedge mclk);
    chk("tap", tap, 5'h1F);
    // clean blanking with the minimum key count
    vblank <= 1'b1;
    repeat (10) @(posedge mclk);
    repeat (4) key;
    vblank <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("ok", bk_ok, 1'b1);
    vblank <= 1'b1;
    repeat (10) @(posedge mclk);
    repeat (16) key;
    chk("cal", cal, 1'b1);
    key;
    chk("cal", cal, 1'b0);
    chk("bk", bk, 5'h11);
    repeat (16) key;
    chk("bk", bk, 5'h01);
    vblank <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("ok", bk_ok, 1'b0);
    // mid-run reset returns both registers to their preset
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("tap", tap, 5'h01);
    chk("sc", sc, 1'b0);
    chk("peak", {cor, pdly, peak_freq_low_select, gcode}, 7'h01);
    rd(8'h10);
    chk("rd", {q0, q1}, 16'h0101);
    complete_run;
  end
endmodule // tb_luma_delay_peaking_ctrl
